// ===== pd_ctrl_pkg.sv
package pd_ctrl_pkg;
    // Register byte addresses on the Wishbone slave
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TIMING = 8'h08;
    localparam logic [7:0] ADDR_PDTIME = 8'h0c;
    // Control fields
    localparam int CTRL_PD_REQ = 0;
    localparam int CTRL_PD_EXIT = 1;
    localparam int CTRL_SRX_NOP = 2;
    localparam int CTRL_ODT_BUF_DIS = 3;
    localparam int CTRL_RTT_NOM_EN = 4;
    localparam int CTRL_ODT_LEVEL = 5;
    localparam int CTRL_DLL_UNLOCKED = 6;
    localparam int CTRL_PAR_CAL_OFF = 7;
    // Status fields
    localparam int ST_IN_PD = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_CMD_OK = 2;
    localparam int ST_DLL_RESET_NEEDED = 3;
    localparam int ST_SRX_REFUSED = 4;
    localparam int ST_PD_LIMIT = 5;
    localparam int ST_CKE = 6;
    // Reset values of timing fields, in clock cycles; PD_MAX_REFI counts refresh intervals
    localparam logic [7:0] TCKE_RST = 8'h04;
    localparam logic [7:0] TCPDED_RST = 8'h04;
    localparam logic [7:0] TXP_RST = 8'h06;
    localparam logic [7:0] TMPX_RST = 8'h08;
    localparam logic [31:0] PD_LIMIT_RST = 32'h0000_fde8;
    localparam int PD_MAX_REFI = 9;
    // Command encodings driven on the command pins: {cs_n, act_n, ras_n, cas_n, we_n}
    localparam logic [4:0] CMD_DES = 5'h1f;
    localparam logic [4:0] CMD_NOP = 5'h0f;
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_ENTER = 6'h02,
        S_PD = 6'h04,
        S_EXIT = 6'h08,
        S_XP = 6'h10,
        S_SRX = 6'h20
    } pd_state_t;
endpackage : pd_ctrl_pkg

// ===== pd_timer_if.sv
`timescale 1ns/1ns
interface pd_timer_if;
    logic load;
    logic [31:0] count;
    logic done;
    modport owner(output load, output count, input done);
    modport timer(input load, input count, output done);
endinterface : pd_timer_if

// ===== pd_timer.sv
`timescale 1ns/1ns
module pd_timer (
    input wire logic clk_i,
    input wire logic reset_i,
    pd_timer_if.timer t
);
    typedef struct packed {
        logic [31:0] cnt;
        logic done;
    } tmr_state_t;
    tmr_state_t s_q;
    tmr_state_t s_d;
    always_comb begin
        s_d = s_q;
        if (t.load) begin
            s_d.cnt = t.count;
            s_d.done = (t.count == 32'h0);
        end else if (s_q.cnt > 32'h1) begin
            s_d.cnt = s_q.cnt - 32'h1;
        end else begin
            s_d.cnt = 32'h0;
            s_d.done = 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '{cnt: 32'h0, done: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end
    assign t.done = s_q.done;
endmodule : pd_timer

// ===== pin_sync.sv
`timescale 1ns/1ns
module pin_sync (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic pin_i,
    output logic level_o
);
    typedef struct packed {
        logic [2:0] ff;
        logic level;
    } sync_state_t;
    sync_state_t s_q;
    sync_state_t s_d;
    always_comb begin
        s_d = s_q;
        s_d.ff = {s_q.ff[1:0], pin_i};
        // Change counts once stages two and three agree
        if (s_q.ff[1] == s_q.ff[2]) begin
            s_d.level = s_q.ff[2];
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '{ff: 3'h0, level: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end
    assign level_o = s_q.level;
endmodule : pin_sync

// ===== pd_ctrl.sv
// Operation
// - NOP exit of self refresh only if parity and CA latency were off.
// - Only NOPs are driven during the exit hold window after self refresh exit.
// - NOP exit never uses fast or abort exit timing.
// - CKE stays high while MRS, MPR, ZQ, DLL lock, read or write run.
// - Deselects are driven through the pass-disable delay around each CKE edge.
// - CKE low held for minimum pulse; power-down limited to nine refresh intervals (here: pd_limit cycles, reset 65000).
// - Exit with CKE high and deselect; CKE held high minimum pulse.
// - ODT driven valid at exit whenever nominal termination is enabled.
// - Exit latency waited after CKE high before any valid command.
// - Minimum power-down time passes before CKE is raised.
// - DLL reset required after exit if DLL was unlocked on entry.
// - ODT held valid on entry; may float only after pass-disable delay.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
module pd_ctrl
    import pd_ctrl_pkg::*;
#(
    parameter int TREFI_CYCLES = 1950,
    parameter int CNT_W = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Busy indication from the command scheduler (MRS, MPR, ZQ, DLL lock, RD/WR)
    input wire logic op_busy_i,
    // Device pins
    input wire logic reset_pin_n_i,
    output logic cke_o,
    output logic [4:0] cmd_o,
    output logic odt_o,
    output logic odt_oe_o,
    output logic dram_reset_n_o,
    output logic cmd_allowed_o
);
    // Refused at elaboration: the timing fields are eight bits wide
    if (CNT_W < 8 || TREFI_CYCLES < 1) begin : g_param_check
        $error("pd_ctrl: unsupported parameters");
    end

    typedef struct packed {
        pd_state_t st;
        logic [7:0] ctrl;
        logic [7:0] tcke;
        logic [7:0] tcpded;
        logic [7:0] txp;
        logic [7:0] tmpx;
        logic [31:0] pd_limit;
        logic dll_reset_needed;
        logic srx_refused;
        logic pd_limit_hit;
        logic [7:0] edge_cnt;
        logic cke;
        logic [4:0] cmd;
        logic odt_oe;
        logic cmd_ok;
        logic ack;
        logic [31:0] rdata;
        logic pin_rst_n;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;
    logic pin_level;

    pd_timer_if tmr_if ();
    pd_timer u_timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .t(tmr_if.timer)
    );
    pin_sync u_rst_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .pin_i(reset_pin_n_i),
        .level_o(pin_level)
    );

    logic wb_req;
    logic [31:0] status;
    assign wb_req = wb_cyc_i && wb_stb_i && !s_q.ack;

    always_comb begin
        status = 32'h0;
        status[ST_IN_PD] = (s_q.st == S_PD);
        status[ST_BUSY] = (s_q.st != S_IDLE);
        status[ST_CMD_OK] = s_q.cmd_ok;
        status[ST_DLL_RESET_NEEDED] = s_q.dll_reset_needed;
        status[ST_SRX_REFUSED] = s_q.srx_refused;
        status[ST_PD_LIMIT] = s_q.pd_limit_hit;
        status[ST_CKE] = s_q.cke;
    end

    always_comb begin
        s_d = s_q;
        tmr_if.load = 1'b0;
        tmr_if.count = 32'h0;
        s_d.ack = wb_req;
        s_d.pin_rst_n = pin_level;
        if (wb_req && wb_we_i) begin
            if (wb_adr_i == ADDR_CTRL) begin
                if (wb_sel_i[0]) begin
                    s_d.ctrl = wb_dat_i[7:0];
                end
            end else if (wb_adr_i == ADDR_TIMING) begin
                if (wb_sel_i[0]) s_d.tcke = wb_dat_i[7:0];
                if (wb_sel_i[1]) s_d.tcpded = wb_dat_i[15:8];
                if (wb_sel_i[2]) s_d.txp = wb_dat_i[23:16];
                if (wb_sel_i[3]) s_d.tmpx = wb_dat_i[31:24];
            end else if (wb_adr_i == ADDR_PDTIME) begin
                if (wb_sel_i[0]) s_d.pd_limit[7:0] = wb_dat_i[7:0];
                if (wb_sel_i[1]) s_d.pd_limit[15:8] = wb_dat_i[15:8];
                if (wb_sel_i[2]) s_d.pd_limit[23:16] = wb_dat_i[23:16];
                if (wb_sel_i[3]) s_d.pd_limit[31:24] = wb_dat_i[31:24];
            end else if (wb_adr_i == ADDR_STATUS) begin
                // Write one to clear sticky flags
                if (wb_dat_i[ST_SRX_REFUSED]) s_d.srx_refused = 1'b0;
                if (wb_dat_i[ST_DLL_RESET_NEEDED]) s_d.dll_reset_needed = 1'b0;
                if (wb_dat_i[ST_PD_LIMIT]) s_d.pd_limit_hit = 1'b0;
            end
        end
        if (!wb_req) begin
            s_d.rdata = 32'h0;
        end else if (wb_adr_i == ADDR_CTRL) begin
            s_d.rdata = {24'h0, s_q.ctrl};
        end else if (wb_adr_i == ADDR_STATUS) begin
            s_d.rdata = status;
        end else if (wb_adr_i == ADDR_TIMING) begin
            s_d.rdata = {s_q.tmpx, s_q.txp, s_q.tcpded, s_q.tcke};
        end else if (wb_adr_i == ADDR_PDTIME) begin
            s_d.rdata = s_q.pd_limit;
        end else begin
            s_d.rdata = 32'h0;
        end

        if (s_q.edge_cnt != 8'h0) begin
            s_d.edge_cnt = s_q.edge_cnt - 8'h1;
        end

        case (s_q.st)
            S_IDLE: begin
                // No commands while the device is held in reset or CKE is low
                s_d.cmd_ok = s_q.pin_rst_n && s_q.cke;
                s_d.odt_oe = 1'b1;
                if (s_q.ctrl[CTRL_PD_REQ] && !op_busy_i) begin
                    s_d.cmd_ok = 1'b0;
                    s_d.cmd = CMD_DES;
                    s_d.cke = 1'b0;
                    s_d.edge_cnt = s_q.tcpded;
                    if (s_q.ctrl[CTRL_DLL_UNLOCKED]) begin
                        s_d.dll_reset_needed = 1'b1;
                    end
                    tmr_if.load = 1'b1;
                    tmr_if.count = {24'h0, s_q.tcke};
                    s_d.st = S_ENTER;
                end else if (s_q.ctrl[CTRL_SRX_NOP]) begin
                    // Only legal when entry was done with parity and CA latency off
                    if (s_q.ctrl[CTRL_PAR_CAL_OFF]) begin
                        s_d.cmd_ok = 1'b0;
                        s_d.cke = 1'b1;
                        s_d.cmd = CMD_NOP;
                        s_d.edge_cnt = s_q.tmpx;
                        s_d.st = S_SRX;
                    end else begin
                        s_d.srx_refused = 1'b1;
                    end
                    s_d.ctrl[CTRL_SRX_NOP] = 1'b0;
                end
            end
            S_ENTER: begin
                s_d.cmd = CMD_DES;
                if (s_q.edge_cnt == 8'h0 && tmr_if.done) begin
                    // ODT may float only once the pass-disable delay is over
                    s_d.odt_oe = !s_q.ctrl[CTRL_ODT_BUF_DIS];
                    tmr_if.load = 1'b1;
                    tmr_if.count = s_q.pd_limit;
                    s_d.st = S_PD;
                end
            end
            S_PD: begin
                if (tmr_if.done) begin
                    s_d.pd_limit_hit = 1'b1;
                end
                if (!s_q.ctrl[CTRL_PD_REQ] || s_q.ctrl[CTRL_PD_EXIT] || tmr_if.done) begin
                    s_d.odt_oe = s_q.ctrl[CTRL_RTT_NOM_EN] || !s_q.ctrl[CTRL_ODT_BUF_DIS];
                    s_d.cke = 1'b1;
                    s_d.cmd = CMD_DES;
                    s_d.edge_cnt = s_q.tcpded;
                    s_d.ctrl[CTRL_PD_REQ] = 1'b0;
                    s_d.ctrl[CTRL_PD_EXIT] = 1'b0;
                    tmr_if.load = 1'b1;
                    tmr_if.count = {24'h0, s_q.tcke};
                    s_d.st = S_EXIT;
                end
            end
            S_EXIT: begin
                s_d.cmd = CMD_DES;
                if (s_q.edge_cnt == 8'h0 && tmr_if.done) begin
                    tmr_if.load = 1'b1;
                    tmr_if.count = {24'h0, s_q.txp};
                    s_d.st = S_XP;
                end
            end
            S_XP: begin
                s_d.cmd = CMD_DES;
                if (tmr_if.done) begin
                    s_d.cmd_ok = 1'b1;
                    s_d.odt_oe = 1'b1;
                    s_d.st = S_IDLE;
                end
            end
            S_SRX: begin
                // Fixed hold window; fast and abort exit timings are never offered
                s_d.cmd = CMD_NOP;
                if (s_q.edge_cnt == 8'h0) begin
                    s_d.cmd = CMD_DES;
                    tmr_if.load = 1'b1;
                    tmr_if.count = {24'h0, s_q.txp};
                    s_d.st = S_XP;
                end
            end
            default: begin
                s_d.st = S_IDLE;
            end
        endcase

        // Reset pin low forces the device out of power-down
        if (!s_q.pin_rst_n && s_q.st != S_IDLE) begin
            s_d.st = S_IDLE;
            s_d.cke = 1'b0;
            s_d.cmd = CMD_DES;
            s_d.cmd_ok = 1'b0;
            s_d.ctrl[CTRL_PD_REQ] = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '{st: S_IDLE, ctrl: 8'h0, tcke: TCKE_RST, tcpded: TCPDED_RST, txp: TXP_RST,
                     tmpx: TMPX_RST, pd_limit: PD_LIMIT_RST, dll_reset_needed: 1'b0,
                     srx_refused: 1'b0, pd_limit_hit: 1'b0, edge_cnt: 8'h0, cke: 1'b1,
                     cmd: CMD_DES, odt_oe: 1'b1, cmd_ok: 1'b0, ack: 1'b0, rdata: 32'h0,
                     pin_rst_n: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o = s_q.rdata;
    assign wb_ack_o = s_q.ack;
    assign cke_o = s_q.cke;
    assign cmd_o = s_q.cmd;
    assign odt_o = s_q.ctrl[CTRL_ODT_LEVEL];
    assign odt_oe_o = s_q.odt_oe;
    assign dram_reset_n_o = s_q.pin_rst_n;
    assign cmd_allowed_o = s_q.cmd_ok;
endmodule : pd_ctrl

// ===== pd_ctrl_assertions.sv
`timescale 1ns/1ns
module pd_ctrl_assertions
    import pd_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic op_busy_i,
    input wire logic cke_o,
    input wire logic [4:0] cmd_o,
    input wire logic odt_oe_o,
    input wire logic cmd_allowed_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    a_busy_holds_cke: assert property (op_busy_i && cke_o |=> cke_o)
        else $error("cke fell while busy");
    a_des_after_fall: assert property ($fell(cke_o) |-> (cmd_o == CMD_DES) [*4])
        else $error("no deselect after cke fell");
    a_des_after_rise: assert property ($rose(cke_o) && cmd_o == CMD_DES |-> (cmd_o == CMD_DES) [*4])
        else $error("no deselect after cke rose");
    a_cke_low_min: assert property ($fell(cke_o) |=> !cke_o [*3])
        else $error("cke low too short");
    a_cke_high_min: assert property ($rose(cke_o) |=> cke_o [*3])
        else $error("cke high too short");
    a_exit_latency: assert property ($rose(cke_o) |-> !cmd_allowed_o [*8])
        else $error("command allowed too early");
    a_exit_bounded: assert property ($rose(cke_o) && cmd_o == CMD_DES |-> ##[8:40] cmd_allowed_o)
        else $error("command never allowed after exit");
    a_nop_only_window: assert property (cmd_o == CMD_NOP |-> !cmd_allowed_o && cke_o)
        else $error("command allowed during nop window");
    a_odt_entry_hold: assert property ($fell(cke_o) |-> odt_oe_o [*4])
        else $error("odt released inside pass-disable delay");
    a_odt_exit_valid: assert property ($rose(cke_o) |-> ##[0:1] odt_oe_o)
        else $error("odt not driven at exit");
    c_entry: cover property ($fell(cke_o));
    c_exit: cover property ($rose(cke_o) ##[8:40] cmd_allowed_o);
    c_nop_exit: cover property (cmd_o == CMD_NOP);
endmodule : pd_ctrl_assertions

bind pd_ctrl pd_ctrl_assertions chk_u (.clk_i(clk_i), .reset_i(reset_i), .op_busy_i(op_busy_i), .cke_o(cke_o),
    .cmd_o(cmd_o), .odt_oe_o(odt_oe_o), .cmd_allowed_o(cmd_allowed_o));

// ===== dram_dev_model.sv
`timescale 1ns/1ns
module dram_dev_model
    import pd_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic cke_i,
    input wire logic [4:0] cmd_i,
    input wire logic odt_i,
    input wire logic odt_input_buffer_disable_bit,
    input wire logic rtt_nom_en_i,
    input wire logic park_en_i,
    input wire logic banks_open_i,
    output logic in_pd_o,
    output logic rtt_nom_on_o,
    output logic park_on_o,
    output logic active_pd_o,
    output int viol_o
);
    logic cke_q = 1'b1;
    int since_q = 99;
    int viol_q = 0;
    // Receivers stay awake until the pass-disable delay has run out
    wire rx_on = !(in_pd_o && since_q >= int'(TCPDED_RST));
    wire near_edge = cke_i != cke_q || since_q < int'(TCPDED_RST);
    assign active_pd_o = in_pd_o && banks_open_i;
    assign rtt_nom_on_o = rtt_nom_en_i && odt_i === 1'b1 && !(in_pd_o && odt_input_buffer_disable_bit);
    assign park_on_o = park_en_i;
    assign viol_o = viol_q;
    always @(posedge clk_i) begin
        cke_q <= cke_i;
        since_q <= (cke_i != cke_q) ? 0 : since_q + 1;
        if (!reset_n_i) begin
            in_pd_o <= 1'b0;
        end else begin
            // DLL never stops here, so exit needs no relock
            if (cmd_i == CMD_DES && in_pd_o == cke_i) in_pd_o <= !cke_i;
            if (rx_on && near_edge && cmd_i != CMD_DES && cmd_i != CMD_NOP) viol_q <= viol_q + 1;
            if (odt_i !== 1'b0 && odt_i !== 1'b1 && (cke_i ? rtt_nom_en_i : !odt_input_buffer_disable_bit || near_edge))
                viol_q <= viol_q + 1;
        end
    end
endmodule : dram_dev_model

// ===== pd_ctrl_tb.sv
`timescale 1ns/1ns
module pd_ctrl_tb;
    import pd_ctrl_pkg::*;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic req = 1'b0, we = 1'b0, busy = 1'b0, rpin = 1'b1, bufdis = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic ack, cke, odt, oe, drst, allowed, inpd, act, rton, parkon;
    logic [4:0] cmd;
    int err_count = 0, checked = 0, nops = 0, nop_bad = 0, viol, n;
    // The released ODT line floats so the device model can see it
    wire odt_w = oe ? odt : 1'bz;
    always #2 clk_i = ~clk_i;
    pd_ctrl dut_u (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .op_busy_i(busy),
        .reset_pin_n_i(rpin), .cke_o(cke), .cmd_o(cmd), .odt_o(odt), .odt_oe_o(oe), .dram_reset_n_o(drst),
        .cmd_allowed_o(allowed));
    dram_dev_model dev_u (.clk_i(clk_i), .reset_n_i(drst), .cke_i(cke), .cmd_i(cmd), .odt_i(odt_w),
        .odt_input_buffer_disable_bit(bufdis), .rtt_nom_en_i(1'b1), .park_en_i(1'b1), .banks_open_i(1'b1),
        .in_pd_o(inpd), .rtt_nom_on_o(rton), .park_on_o(parkon), .active_pd_o(act), .viol_o(viol));
    always @(posedge clk_i) begin
        nops <= nops + int'(cmd === CMD_NOP);
        nop_bad <= nop_bad + int'(cmd === CMD_NOP && allowed !== 1'b0);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat_o;
        req <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rdat & m, e);
    endtask : rd
    task automatic till(input bit sel, input logic v);
        n = 0;
        while ((sel ? allowed : cke) !== v && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(n < 400), 32'h1);
    endtask : till
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rd(ADDR_TIMING, ALL, {TMPX_RST, TXP_RST, TCPDED_RST, TCKE_RST});
        rd(ADDR_PDTIME, ALL, PD_LIMIT_RST);
        rd(ADDR_STATUS, 32'h7f, 32'h44);
        wb(1'b1, 8'h10, ALL);
        rd(8'h10, ALL, 32'h0);
        $display("done registers");
        busy <= 1'b1;
        wb(1'b1, ADDR_CTRL, 32'h1);
        repeat (8) @(posedge clk_i);
        chk(32'(cke), 32'h1);
        busy <= 1'b0;
        till(1'b0, 1'b0);
        repeat (6) @(posedge clk_i);
        chk(32'({inpd, act}), 32'h3);
        wb(1'b1, ADDR_CTRL, 32'h2);
        till(1'b0, 1'b1);
        till(1'b1, 1'b1);
        chk(32'(n >= int'(TCPDED_RST + TXP_RST)), 32'h1);
        chk(32'(inpd), 32'h0);
        $display("done entry and exit");
        for (int b = 0; b < 2; b++) begin
            bufdis <= b[0];
            wb(1'b1, ADDR_CTRL, {28'h3, b[0], 3'h1});
            till(1'b0, 1'b0);
            repeat (8) @(posedge clk_i);
            chk(32'({oe, rton, parkon}), {29'h0, !b[0], !b[0], 1'b1});
            wb(1'b1, ADDR_CTRL, {28'h3, b[0], 3'h2});
            till(1'b0, 1'b1);
            @(posedge clk_i);
            chk(32'(oe), 32'h1);
            till(1'b1, 1'b1);
        end
        $display("done odt buffer");
        wb(1'b1, ADDR_CTRL, 32'h41);
        till(1'b0, 1'b0);
        repeat (6) @(posedge clk_i);
        wb(1'b1, ADDR_CTRL, 32'h42);
        till(1'b1, 1'b1);
        rd(ADDR_STATUS, 32'h8, 32'h8);
        wb(1'b1, ADDR_STATUS, 32'h8);
        rd(ADDR_STATUS, 32'h8, 32'h0);
        wb(1'b1, ADDR_CTRL, 32'h4);
        repeat (4) @(posedge clk_i);
        chk({31'h0, cke}, 32'h1);
        rd(ADDR_STATUS, 32'h10, 32'h10);
        wb(1'b1, ADDR_STATUS, 32'h10);
        wb(1'b1, ADDR_CTRL, 32'h84);
        till(1'b1, 1'b0);
        till(1'b1, 1'b1);
        chk(nops, 32'(TMPX_RST) + 32'h1);
        chk(nop_bad, 32'h0);
        $display("done nop exit");
        wb(1'b1, ADDR_PDTIME, 32'h0000_0028);
        wb(1'b1, ADDR_CTRL, 32'h1);
        till(1'b0, 1'b0);
        till(1'b0, 1'b1);
        chk(32'(n <= 48), 32'h1);
        rd(ADDR_STATUS, 32'h20, 32'h20);
        till(1'b1, 1'b1);
        $display("done limit");
        wb(1'b1, ADDR_CTRL, 32'h1);
        till(1'b0, 1'b0);
        rpin <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(32'({drst, inpd, allowed}), 32'h0);
        chk(viol, 32'h0);
        $display("done reset pin");
        end_sim();
    end
endmodule : pd_ctrl_tb
